// ---- design/prx_map.vh ----
`ifndef PRX_MAP_VH
`define PRX_MAP_VH

// Register offsets
`define PRX_ADDR_W 5
`define PRX_OFS_FUNCTION_ENABLES 5'h00
`define PRX_OFS_INTEGRATION_TIME 5'h02
`define PRX_OFS_WAIT_TIME 5'h03
`define PRX_OFS_LOW_THRESHOLD_LO 5'h08
`define PRX_OFS_LOW_THRESHOLD_HI 5'h09
`define PRX_OFS_HIGH_THRESHOLD_LO 5'h0A
`define PRX_OFS_HIGH_THRESHOLD_HI 5'h0B
`define PRX_OFS_INTERRUPT_PERSISTENCE 5'h0C
`define PRX_OFS_WAIT_CONFIG 5'h0D
`define PRX_OFS_IR_PULSE_COUNT 5'h0E
`define PRX_OFS_STATUS 5'h13

// Field positions
`define PRX_BIT_POWER_ON 0
`define PRX_BIT_PROX_ON_LO 1
`define PRX_BIT_PROX_ON_HI 2
`define PRX_BIT_WAIT_ENABLE 3
`define PRX_BIT_IRQ_MASK 5
`define PRX_BIT_LONG_WAIT 1
`define PRX_BIT_IRQ_PENDING 5
`define PRX_INTERRUPT_PERSISTENCE_HI 7
`define PRX_INTERRUPT_PERSISTENCE_LO 4

// Reset values
`define PRX_RST_FUNCTION_ENABLES 8'h00
`define PRX_RST_INTEGRATION_TIME 8'hFF
`define PRX_RST_WAIT_TIME 8'hFF
`define PRX_RST_THRESHOLD 8'h00
`define PRX_RST_PERSISTENCE 4'h0
`define PRX_RST_PULSE_COUNT 8'h00

// Timing
`define PRX_CLK_HZ 10000000
`define PRX_UNIT_NS 2720000
`define PRX_CLK_PERIOD_NS 100
`define PRX_UNIT_CYCLES (`PRX_UNIT_NS / `PRX_CLK_PERIOD_NS)
`define PRX_PULSE_RATE_HZ 62500
`define PRX_PULSE_CYCLES (`PRX_CLK_HZ / `PRX_PULSE_RATE_HZ)
`define PRX_LONG_FACTOR 12
`define PRX_STEP_SPAN 256

`endif

// ---- design/prx_control_regs.v ----
// Contract
// - Enable register at 0x00: power-on, proximity enable, wait enable, interrupt mask.
// - No proximity operation until 2.72 ms after power-on is set.
// - Hardware enforces the power-on delay even if proximity is enabled early.
// - Integration time from register 0x02, in 2.72 ms steps.
// - Wait unit is 2.72 ms, twelve times longer with long wait.
// - Wait register 0x03 gives 256 minus value units.
// - Long wait is bit 1 of configuration register 0x0D.
// - Low and high 16-bit thresholds at 0x08 to 0x0B, low byte first.
// - Result below low or above high threshold is out of range.
// - Persistence zero raises interrupt after every integration cycle.
// - Persistence N raises interrupt after N consecutive out-of-range results.
// - Emit pulse-count register 0x0E pulses per cycle at 62.5 kHz.
// - Pending interrupt reads in bit 5 of status register 0x13.
// - Result kept as 16 bits and compared against thresholds.
`timescale 1ns/1ps
`include "prx_map.vh"

module prx_control_regs
#(
   parameter UNIT_CYCLES = `PRX_UNIT_CYCLES
)
(
   input wire clk,
   input wire rst,
   input wire [`PRX_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_ff,
   input wire irq_clear,
   input wire [15:0] prox_count,
   output reg ir_led_ff,
   output reg integrating_ff,
   output wire irq_out,
   output wire irq_oe
);

   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_PULSE = 5'h02;
   localparam [4:0] ST_INTEG = 5'h04;
   localparam [4:0] ST_WAIT = 5'h08;
   localparam [4:0] ST_SPARE = 5'h10;
   localparam [31:0] UNIT_CYCLES_W = UNIT_CYCLES;
   localparam [31:0] PULSE_CYCLES_W = `PRX_PULSE_CYCLES;
   localparam [23:0] UNIT_LAST = UNIT_CYCLES_W[23:0] - 24'h000001;
   localparam [7:0] PULSE_LAST = PULSE_CYCLES_W[7:0] - 8'h01;
   localparam [7:0] PULSE_HALF = PULSE_CYCLES_W[8:1];
   localparam [8:0] STEP_SPAN = `PRX_STEP_SPAN;
   localparam [3:0] LONG_FACTOR = `PRX_LONG_FACTOR;

   reg power_on_bit_ff;
   reg [1:0] prox_function_on_ff;
   reg wait_enable_ff;
   reg prox_irq_mask_ff;
   reg [7:0] integration_time_ff;
   reg [7:0] wait_time_ff;
   reg [7:0] low_threshold_lo_ff;
   reg [7:0] low_threshold_hi_ff;
   reg [7:0] high_threshold_lo_ff;
   reg [7:0] high_threshold_hi_ff;
   reg [3:0] irq_persistence_ff;
   reg long_wait_select_ff;
   reg [7:0] ir_pulse_count_ff;
   reg prox_irq_pending_ff;
   reg [15:0] result_ff;
   reg [3:0] oor_cnt_ff;
   reg [23:0] warm_cnt_ff;
   reg warm_done_ff;
   reg [4:0] state_ff;
   reg [23:0] tick_ff;
   reg [11:0] units_ff;
   reg [7:0] phase_ff;
   reg [7:0] pulses_ff;

   reg [4:0] nxt_state;
   reg [23:0] nxt_tick;
   reg [11:0] nxt_units;
   reg [7:0] nxt_phase;
   reg [7:0] nxt_pulses;
   reg nxt_result_take;
   reg [7:0] nxt_rdata;

   wire prox_on = (prox_function_on_ff == 2'b11);
   wire unit_end = (tick_ff == UNIT_LAST);
   wire step_end = unit_end && (units_ff == 12'h001);
   wire [15:0] low_threshold = {low_threshold_hi_ff, low_threshold_lo_ff};
   wire [15:0] high_threshold = {high_threshold_hi_ff, high_threshold_lo_ff};
   wire [11:0] integ_units = {3'h0, STEP_SPAN - {1'b0, integration_time_ff}};
   wire [11:0] wait_base = {3'h0, STEP_SPAN - {1'b0, wait_time_ff}};
   wire [15:0] wait_prod = wait_base * LONG_FACTOR;
   wire [11:0] wait_units = long_wait_select_ff ? wait_prod[11:0] : wait_base;
   wire out_of_range = (prox_count < low_threshold) || (prox_count > high_threshold);
   wire [3:0] oor_next = (oor_cnt_ff == 4'hF) ? 4'hF : oor_cnt_ff + 4'h1;
   wire hit_event = (irq_persistence_ff == 4'h0) ||
                    (out_of_range && (oor_next >= irq_persistence_ff));
   wire may_start = power_on_bit_ff && prox_on && warm_done_ff;

   // Register file
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         power_on_bit_ff <= 1'b0;
         prox_function_on_ff <= 2'b00;
         wait_enable_ff <= 1'b0;
         prox_irq_mask_ff <= 1'b0;
         integration_time_ff <= `PRX_RST_INTEGRATION_TIME;
         wait_time_ff <= `PRX_RST_WAIT_TIME;
         low_threshold_lo_ff <= `PRX_RST_THRESHOLD;
         low_threshold_hi_ff <= `PRX_RST_THRESHOLD;
         high_threshold_lo_ff <= `PRX_RST_THRESHOLD;
         high_threshold_hi_ff <= `PRX_RST_THRESHOLD;
         irq_persistence_ff <= `PRX_RST_PERSISTENCE;
         long_wait_select_ff <= 1'b0;
         ir_pulse_count_ff <= `PRX_RST_PULSE_COUNT;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `PRX_OFS_FUNCTION_ENABLES:
            begin
               power_on_bit_ff <= reg_wdata[`PRX_BIT_POWER_ON];
               prox_function_on_ff <= reg_wdata[`PRX_BIT_PROX_ON_HI:`PRX_BIT_PROX_ON_LO];
               wait_enable_ff <= reg_wdata[`PRX_BIT_WAIT_ENABLE];
               prox_irq_mask_ff <= reg_wdata[`PRX_BIT_IRQ_MASK];
            end
            `PRX_OFS_INTEGRATION_TIME: integration_time_ff <= reg_wdata;
            `PRX_OFS_WAIT_TIME: wait_time_ff <= reg_wdata;
            `PRX_OFS_LOW_THRESHOLD_LO: low_threshold_lo_ff <= reg_wdata;
            `PRX_OFS_LOW_THRESHOLD_HI: low_threshold_hi_ff <= reg_wdata;
            `PRX_OFS_HIGH_THRESHOLD_LO: high_threshold_lo_ff <= reg_wdata;
            `PRX_OFS_HIGH_THRESHOLD_HI: high_threshold_hi_ff <= reg_wdata;
            `PRX_OFS_INTERRUPT_PERSISTENCE:
               irq_persistence_ff <= reg_wdata[`PRX_INTERRUPT_PERSISTENCE_HI:`PRX_INTERRUPT_PERSISTENCE_LO];
            `PRX_OFS_WAIT_CONFIG: long_wait_select_ff <= reg_wdata[`PRX_BIT_LONG_WAIT];
            `PRX_OFS_IR_PULSE_COUNT: ir_pulse_count_ff <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Read mux; reserved bits and unmapped offsets read as zero
   always @*
   begin
      nxt_rdata = 8'h00;
      case (reg_addr)
         `PRX_OFS_FUNCTION_ENABLES:
         begin
            nxt_rdata[`PRX_BIT_POWER_ON] = power_on_bit_ff;
            nxt_rdata[`PRX_BIT_PROX_ON_HI:`PRX_BIT_PROX_ON_LO] = prox_function_on_ff;
            nxt_rdata[`PRX_BIT_WAIT_ENABLE] = wait_enable_ff;
            nxt_rdata[`PRX_BIT_IRQ_MASK] = prox_irq_mask_ff;
         end
         `PRX_OFS_INTEGRATION_TIME: nxt_rdata = integration_time_ff;
         `PRX_OFS_WAIT_TIME: nxt_rdata = wait_time_ff;
         `PRX_OFS_LOW_THRESHOLD_LO: nxt_rdata = low_threshold_lo_ff;
         `PRX_OFS_LOW_THRESHOLD_HI: nxt_rdata = low_threshold_hi_ff;
         `PRX_OFS_HIGH_THRESHOLD_LO: nxt_rdata = high_threshold_lo_ff;
         `PRX_OFS_HIGH_THRESHOLD_HI: nxt_rdata = high_threshold_hi_ff;
         `PRX_OFS_INTERRUPT_PERSISTENCE:
            nxt_rdata[`PRX_INTERRUPT_PERSISTENCE_HI:`PRX_INTERRUPT_PERSISTENCE_LO] = irq_persistence_ff;
         `PRX_OFS_WAIT_CONFIG: nxt_rdata[`PRX_BIT_LONG_WAIT] = long_wait_select_ff;
         `PRX_OFS_IR_PULSE_COUNT: nxt_rdata = ir_pulse_count_ff;
         `PRX_OFS_STATUS: nxt_rdata[`PRX_BIT_IRQ_PENDING] = prox_irq_pending_ff;
         default: nxt_rdata = 8'h00;
      endcase
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         reg_rdata_ff <= 8'h00;
      else if (reg_rd)
         reg_rdata_ff <= nxt_rdata;
   end

   // Oscillator warm-up, restarted whenever power-on is cleared
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         warm_cnt_ff <= 24'h000000;
         warm_done_ff <= 1'b0;
      end
      else if (!power_on_bit_ff)
      begin
         warm_cnt_ff <= 24'h000000;
         warm_done_ff <= 1'b0;
      end
      else if (!warm_done_ff)
      begin
         if (warm_cnt_ff == UNIT_LAST)
            warm_done_ff <= 1'b1;
         else
            warm_cnt_ff <= warm_cnt_ff + 24'h000001;
      end
   end

   // Measurement sequencer
   always @*
   begin
      nxt_state = state_ff;
      nxt_tick = unit_end ? 24'h000000 : tick_ff + 24'h000001;
      nxt_units = unit_end ? units_ff - 12'h001 : units_ff;
      nxt_phase = 8'h00;
      nxt_pulses = 8'h00;
      nxt_result_take = 1'b0;
      case (state_ff)
         ST_IDLE:
         begin
            nxt_tick = 24'h000000;
            nxt_units = integ_units;
            if (may_start)
            begin
               if (ir_pulse_count_ff == 8'h00)
                  nxt_state = ST_INTEG;
               else
                  nxt_state = ST_PULSE;
            end
         end
         ST_PULSE:
         begin
            nxt_tick = 24'h000000;
            nxt_units = integ_units;
            nxt_phase = (phase_ff == PULSE_LAST) ? 8'h00 : phase_ff + 8'h01;
            nxt_pulses = pulses_ff;
            if (phase_ff == PULSE_LAST)
            begin
               nxt_pulses = pulses_ff + 8'h01;
               if ({1'b0, pulses_ff} + 9'h001 >= {1'b0, ir_pulse_count_ff})
                  nxt_state = ST_INTEG;
            end
         end
         ST_INTEG:
         begin
            if (step_end)
            begin
               nxt_result_take = 1'b1;
               nxt_units = wait_units;
               if (wait_enable_ff)
                  nxt_state = ST_WAIT;
               else if (prox_on)
                  nxt_state = (ir_pulse_count_ff == 8'h00) ? ST_INTEG : ST_PULSE;
               else
                  nxt_state = ST_IDLE;
               if (!wait_enable_ff)
                  nxt_units = integ_units;
            end
         end
         ST_WAIT:
         begin
            if (step_end)
            begin
               nxt_units = integ_units;
               if (prox_on)
                  nxt_state = (ir_pulse_count_ff == 8'h00) ? ST_INTEG : ST_PULSE;
               else
                  nxt_state = ST_IDLE;
            end
         end
         default:
         begin
            nxt_state = ST_IDLE;
            nxt_tick = 24'h000000;
            nxt_units = integ_units;
         end
      endcase
      // Power-off stops at once; the oscillator is gone
      if (!power_on_bit_ff)
      begin
         nxt_state = ST_IDLE;
         nxt_tick = 24'h000000;
         nxt_result_take = 1'b0;
      end
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff <= ST_IDLE;
         tick_ff <= 24'h000000;
         units_ff <= 12'h001;
         phase_ff <= 8'h00;
         pulses_ff <= 8'h00;
         ir_led_ff <= 1'b0;
         integrating_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         tick_ff <= nxt_tick;
         units_ff <= nxt_units;
         phase_ff <= nxt_phase;
         pulses_ff <= nxt_pulses;
         ir_led_ff <= (nxt_state == ST_PULSE) && (nxt_phase < PULSE_HALF);
         integrating_ff <= (nxt_state == ST_INTEG);
      end
   end

   // Result capture and interrupt filter
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         result_ff <= 16'h0000;
         oor_cnt_ff <= 4'h0;
         prox_irq_pending_ff <= 1'b0;
      end
      else
      begin
         if (nxt_result_take)
         begin
            result_ff <= prox_count;
            oor_cnt_ff <= out_of_range ? oor_next : 4'h0;
         end
         // Set wins over a clear in the same cycle
         if (nxt_result_take && hit_event)
            prox_irq_pending_ff <= 1'b1;
         else if (irq_clear)
            prox_irq_pending_ff <= 1'b0;
      end
   end

   // Open-drain, active low: drive low only while pending and unmasked
   assign irq_out = 1'b0;
   assign irq_oe = prox_irq_pending_ff && prox_irq_mask_ff;

endmodule // prx_control_regs

// ---- bench/prx_props.sv ----
`timescale 1ns/1ps
`include "prx_map.vh"
module prx_props
#(
   parameter UNIT_CYCLES = `PRX_UNIT_CYCLES
)
(
   input wire clk,
   input wire rst,
   input wire [`PRX_ADDR_W-1:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata_ff,
   input wire irq_clear,
   input wire ir_led_ff,
   input wire integrating_ff,
   input wire irq_out,
   input wire irq_oe
);
   reg [7:0] led_n_ff;
   reg [23:0] int_n_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Run lengths of the pulse and integration steps
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         led_n_ff <= 8'h00;
         int_n_ff <= 24'h000000;
      end
      else
      begin
         led_n_ff <= ir_led_ff ? led_n_ff + 8'h01 : 8'h00;
         int_n_ff <= integrating_ff ? int_n_ff + 24'h000001 : 24'h000000;
      end
   end
   sequence s_status_rd;
      reg_rd && reg_addr == 5'h13 && irq_oe;
   endsequence
   sequence s_led_end;
      $fell(ir_led_ff);
   endsequence
   sequence s_integ_end;
      $fell(integrating_ff);
   endsequence
   pin_level_a: assert property (irq_out == 1'h0)
      else $error("irq pin value not low");
   irq_hold_a: assert property (irq_oe && !irq_clear && !reg_wr |=> irq_oe)
      else $error("interrupt dropped without clear");
   rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_ff))
      else $error("read data changed without read");
   enable_rsvd_a: assert property (reg_rd && reg_addr == 5'h00 |=> reg_rdata_ff[7:6] == 2'h0 && !reg_rdata_ff[4])
      else $error("reserved enable bits read nonzero");
   status_bit_a: assert property (s_status_rd |=> reg_rdata_ff[5])
      else $error("status misses pending interrupt");
   pulse_width_a: assert property (s_led_end |-> led_n_ff == 8'h50)
      else $error("pulse high time wrong");
   integ_len_a: assert property (s_integ_end |-> int_n_ff % UNIT_CYCLES == 0 && int_n_ff != 0)
      else $error("integration not whole units");
   step_excl_a: assert property (!(ir_led_ff && integrating_ff))
      else $error("pulses overlap integration");
endmodule // prx_props
bind prx_control_regs prx_props #(.UNIT_CYCLES(UNIT_CYCLES)) u_props (.clk(clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
   .irq_clear(irq_clear), .ir_led_ff(ir_led_ff), .integrating_ff(integrating_ff),
   .irq_out(irq_out), .irq_oe(irq_oe));

// ---- bench/prx_host.sv ----
`timescale 1ns/1ps
`include "prx_map.vh"
module prx_host
(
   input wire clk,
   output reg [`PRX_ADDR_W-1:0] reg_addr,
   output reg [7:0] reg_wdata,
   output reg reg_wr,
   output reg reg_rd,
   input wire [7:0] reg_rdata_ff,
   input wire irq_out,
   input wire irq_oe,
   output wire irq_n
);
   // Open-drain line with pull-up
   assign irq_n = irq_oe ? irq_out : 1'h1;
   initial
   begin
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
   end
   // Idle lines show the inverse so stale values never pass
   task wr(input [`PRX_ADDR_W-1:0] a, input [7:0] d);
   begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   end
   endtask
   task rd(input [`PRX_ADDR_W-1:0] a, output [7:0] d);
   begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata_ff;
   end
   endtask
endmodule // prx_host

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`include "prx_map.vh"
module tb_top;
   localparam int UC = 20;
   localparam [23:0] ROWS [0:11] = '{24'h00D808, 24'h028080, 24'h03B6B6, 24'h083434,
      24'h091212, 24'h0A7878, 24'h0B5656, 24'h0CFFF0, 24'h0DFF02, 24'h0E2020, 24'h13FF00,
      24'h01AA00};
   localparam [15:0] RST [0:7] = '{16'h0000, 16'h02FF, 16'h03FF, 16'h0C00, 16'h0D00,
      16'h0E00, 16'h0B00, 16'h1300};
   localparam [7:0] WT [0:2] = '{8'hFE, 8'hFE, 8'h00};
   localparam [7:0] LW [0:2] = '{8'h00, 8'h02, 8'h00};
   localparam int WU [0:2] = '{2, 24, 256};
   reg clk = 1'h0;
   reg rst = 1'h1;
   reg irq_clear = 1'h0;
   reg [15:0] prox_count = 16'h3000;
   wire [`PRX_ADDR_W-1:0] reg_addr;
   wire [7:0] reg_wdata, reg_rdata_ff;
   wire reg_wr, reg_rd, ir_led_ff, integrating_ff, irq_out, irq_oe, irq_n;
   int miscompares = 0;
   int total_checks = 0;
   int n, i;
   reg [7:0] d;
   always #50 clk = ~clk;
   prx_control_regs #(.UNIT_CYCLES(UC)) DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
      .irq_clear(irq_clear), .prox_count(prox_count), .ir_led_ff(ir_led_ff),
      .integrating_ff(integrating_ff), .irq_out(irq_out), .irq_oe(irq_oe));
   prx_host HOST (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .irq_out(irq_out), .irq_oe(irq_oe),
      .irq_n(irq_n));
   task chk(input [15:0] got, input [15:0] exp);
   begin
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task rdc(input [`PRX_ADDR_W-1:0] a, input [7:0] e);
   begin
      HOST.rd(a, d);
      chk({8'h00, d}, {8'h00, e});
   end
   endtask
   task step;
   begin
      @(posedge clk);
      #1;
      n++;
   end
   endtask
   task integ_end;
   begin
      n = 0;
      while (integrating_ff !== 1'h1 && n < 9000) step;
      while (integrating_ff === 1'h1 && n < 9000) step;
      step;
   end
   endtask
   task clr;
   begin
      @(posedge clk) irq_clear <= 1'h1;
      @(posedge clk) irq_clear <= 1'h0;
      step;
   end
   endtask
   task end_of_test;
   begin
      if (miscompares == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask
   initial
   begin
      #(30000 * 100);
      miscompares++;
      end_of_test;
   end
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      for (i = 0; i < 12; i++)
      begin
         HOST.wr(ROWS[i][20:16], ROWS[i][15:8]);
         rdc(ROWS[i][20:16], ROWS[i][7:0]);
      end
      HOST.wr(5'h0E, 8'h02);
      HOST.wr(5'h03, 8'hFF);
      HOST.wr(5'h02, 8'hFF);
      HOST.wr(5'h0C, 8'h00);
      HOST.wr(5'h00, 8'h27);
      n = 0;
      while (ir_led_ff !== 1'h1 && n < 500) step;
      chk(16'(n >= UC), 16'h0001);
      n = 0;
      while (integrating_ff !== 1'h1 && n < 500) step;
      chk(n[15:0], 16'h0140);
      n = 0;
      while (integrating_ff === 1'h1 && n < 500) step;
      chk(n[15:0], 16'(UC));
      step;
      chk(16'(irq_n), 16'h0000);
      rdc(5'h13, 8'h20);
      clr;
      chk(16'(irq_n), 16'h0001);
      HOST.wr(5'h0C, 8'h20);
      HOST.wr(5'h00, 8'h07);
      clr;
      @(posedge clk) prox_count <= 16'h1233;
      integ_end;
      rdc(5'h13, 8'h00);
      integ_end;
      rdc(5'h13, 8'h20);
      chk(16'(irq_n), 16'h0001);
      HOST.wr(5'h00, 8'h27);
      step;
      chk(16'(irq_n), 16'h0000);
      @(posedge clk) prox_count <= 16'h5678;
      clr;
      integ_end;
      rdc(5'h13, 8'h00);
      @(posedge clk) prox_count <= 16'h5679;
      integ_end;
      rdc(5'h13, 8'h00);
      integ_end;
      rdc(5'h13, 8'h20);
      HOST.wr(5'h0E, 8'h00);
      HOST.wr(5'h00, 8'h0F);
      for (i = 0; i < 3; i++)
      begin
         HOST.wr(5'h03, WT[i]);
         HOST.wr(5'h0D, LW[i]);
         integ_end;
         n = 0;
         while (integrating_ff !== 1'h1 && n < 9000) step;
         chk(16'(n >= WU[i] * UC - 2 && n <= WU[i] * UC + 2), 16'h0001);
      end
      HOST.wr(5'h00, 8'h01);
      integ_end;
      repeat (60) step;
      chk(16'(integrating_ff), 16'h0000);
      @(posedge clk) rst <= 1'h1;
      step;
      chk({13'h0000, irq_n, ir_led_ff, integrating_ff}, 16'h0004);
      @(posedge clk) rst <= 1'h0;
      for (i = 0; i < 8; i++)
         rdc(RST[i][12:8], RST[i][7:0]);
      end_of_test;
   end
endmodule // tb_top
